// [shared/timer_pkg.sv]
// Purpose: constants and types shared by the dual prescaled timer block
// Assumes: classic wishbone slave, 32-bit data, byte addressing
// Notes:   register offsets are full byte addresses of the register page
package timer_pkg;

    localparam logic [31:0] RTC_COUNT_ADDR    = 32'h01F80080;
    localparam logic [31:0] RTC_PRESCALE_ADDR = 32'h01F80084;
    localparam logic [31:0] GP_COUNT_ADDR     = 32'h01F80088;
    localparam logic [31:0] GP_PRESCALE_ADDR  = 32'h01F8008C;
    localparam logic [31:0] TIMER_CTRL_ADDR   = 32'h01F80098;
    localparam logic [31:0] IRQ_STATUS_ADDR   = 32'h01F800C0;
    localparam logic [31:0] IRQ_CLEAR_ADDR    = 32'h01F800C4;
    localparam logic [31:0] IRQ_ENABLE_ADDR   = 32'h01F800C8;

    // control register bit positions
    localparam int GP_RELOAD_AT_ZERO_BIT  = 0;
    localparam int GP_COUNT_LOAD_BIT      = 1;
    localparam int GP_COUNT_ENABLE_BIT    = 2;
    localparam int GP_PRESCALE_LOAD_BIT   = 3;
    localparam int RTC_RELOAD_AT_ZERO_BIT = 8;
    localparam int RTC_COUNT_LOAD_BIT     = 9;
    localparam int RTC_COUNT_ENABLE_BIT   = 10;
    localparam int RTC_PRESCALE_LOAD_BIT  = 11;

    // interrupt status bit positions
    localparam int IRQ_RTC_BIT = 0;
    localparam int IRQ_GP_BIT  = 1;

    // reset values
    localparam logic [31:0] COUNT_RESET        = 32'hFFFFFFFF;
    localparam logic [7:0]  RTC_PRESCALE_RESET = 8'hFF;
    localparam logic [15:0] GP_PRESCALE_RESET  = 16'hFFFF;
    localparam logic        RTC_RELOAD_RESET   = 1'b1;
    localparam logic        GP_RELOAD_RESET    = 1'b0;

    // behaviour of one timer channel as set by the control register
    typedef struct packed {
        logic reload_at_zero;
        logic enable;
    } timer_mode_t;

    // one-cycle load strobes for one timer channel
    typedef struct packed {
        logic count_load;
        logic prescale_load;
    } timer_load_t;

endpackage

// [src/dual_prescaled_down_timers.sv]
// Purpose: real time clock timer and general purpose timer, each a 32-bit
//          down counter behind its own down-counting prescaler
// Assumes: classic wishbone slave on clk_i, synchronous active-high reset
// Notes:   counter and prescaler addresses read the live value and write the preset
//          writes land on the edge where ack is sampled high, reads are captured one edge earlier
//          a counter loaded with zero never expires; widths above 32 bits need a wider bus
//          interrupt status, clear and enable sit on spare addresses of the register page
//
// Overview of operation
// - readable 32-bit down counters, reset all ones
// - counter write stores preset, read gives live
// - rtc 8-bit prescaler readable, resets to FFh
// - rtc prescaler write stores 8-bit preset
// - gp 16-bit prescaler readable, resets FFFFh
// - gp prescaler write stores 16-bit preset
// - rtc interrupt after count times prescale plus one
// - gp interrupt after count times prescale plus one
// - gp reload bit: reload at zero else stop
// - gp count load bit loads counter preset
// - gp enable bit counts, else both hold
// - gp prescale load bit loads prescaler preset
// - rtc reload bit, resets to one
// - rtc count load bit loads counter preset
// - rtc enable bit counts, else both hold
// - rtc prescale load bit loads prescaler preset
`timescale 1ns/100ps

module dual_prescaled_down_timers
    import timer_pkg::*;
#(
    parameter int COUNT_W        = 32,
    parameter int RTC_PRESCALE_W = 8,
    parameter int GP_PRESCALE_W  = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             rtc_irq_o,
    output logic             gp_irq_o,
    output logic             irq_o
);

    // bus signals
    logic              req;
    logic              rd_stb;
    logic              wr_stb;
    logic [31:0]       wdata;
    logic              ack_r;
    logic [31:0]       dat_r;

    // rtc channel
    logic [COUNT_W-1:0]        rtc_count_value_r;
    logic [COUNT_W-1:0]        rtc_count_preset_r;
    logic [RTC_PRESCALE_W-1:0] rtc_prescale_value_r;
    logic [RTC_PRESCALE_W-1:0] rtc_prescale_preset_r;
    timer_mode_t               rtc_mode_r;
    timer_load_t               rtc_load;
    logic                      rtc_tick;
    logic                      rtc_expire;
    logic                      rtc_irq_r;

    // gp channel
    logic [COUNT_W-1:0]        gp_count_value_r;
    logic [COUNT_W-1:0]        gp_count_preset_r;
    logic [GP_PRESCALE_W-1:0]  gp_prescale_value_r;
    logic [GP_PRESCALE_W-1:0]  gp_prescale_preset_r;
    timer_mode_t               gp_mode_r;
    timer_load_t               gp_load;
    logic                      gp_tick;
    logic                      gp_expire;
    logic                      gp_irq_r;

    // next values of the channel registers
    logic [COUNT_W-1:0]        rtc_count_nxt;
    logic [RTC_PRESCALE_W-1:0] rtc_prescale_nxt;
    logic [COUNT_W-1:0]        gp_count_nxt;
    logic [GP_PRESCALE_W-1:0]  gp_prescale_nxt;

    // interrupt status and enable
    logic [1:0]                irq_status_r;
    logic [1:0]                irq_enable_r;
    logic [1:0]                irq_clear;
    logic [1:0]                irq_set;

    // merge a byte-lane write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // a write to one address on the cycle the slave acks
    function automatic logic hit_wr(input logic [31:0] a);
        return wr_stb && (adr_i == a);
    endfunction

    // one prescaler clock: count down, reload the preset on underflow
    function automatic logic [31:0] prescale_step(input logic [31:0] value,
                                                  input logic [31:0] preset);
        logic [31:0] r;
        if (value == 32'h00000000) begin
            r = preset;
        end else begin
            r = value - 32'h00000001;
        end
        return r;
    endfunction

    // one counter update on a tick: the last step reloads or lands on zero;
    // callers keep the count within 32 bits, the width of the bus word
    function automatic logic [31:0] count_step(input logic [31:0] value,
                                               input logic [31:0] preset,
                                               input logic        tick,
                                               input logic        reload);
        logic [31:0] r;
        r = value;
        if (tick) begin
            if (reload && (value == 32'h00000001)) begin
                r = preset;
            end else begin
                r = value - 32'h00000001;
            end
        end
        return r;
    endfunction

    // one wait state: ack one cycle after the request, dropped the next cycle
    assign req    = cyc_i && stb_i && !ack_r;
    // a write lands on the ack edge, while the master still holds address and data
    assign rd_stb = req && !we_i;
    assign wr_stb = cyc_i && stb_i && we_i && ack_r;
    assign wdata  = dat_i;
    assign ack_o  = ack_r;
    assign dat_o  = dat_r;

    // ack generation; every address answers, unmapped reads return zero
    // ack is registered, so a strobe held high is answered every other cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read mux, registered so read data comes from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h00000000;
        end else if (rd_stb) begin
            // the control and clear registers are write-only and read as zero
            case (adr_i)
                RTC_COUNT_ADDR:    dat_r <= 32'(rtc_count_value_r);
                RTC_PRESCALE_ADDR: dat_r <= 32'(rtc_prescale_value_r);
                GP_COUNT_ADDR:     dat_r <= 32'(gp_count_value_r);
                GP_PRESCALE_ADDR:  dat_r <= 32'(gp_prescale_value_r);
                IRQ_STATUS_ADDR:   dat_r <= 32'(irq_status_r);
                IRQ_ENABLE_ADDR:   dat_r <= 32'(irq_enable_r);
                default:           dat_r <= 32'h00000000;
            endcase
        end else begin
            dat_r <= 32'h00000000;
        end
    end

    // preset registers; writes hold until a load strobe or reload uses them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_count_preset_r    <= COUNT_W'(COUNT_RESET);
            gp_count_preset_r     <= COUNT_W'(COUNT_RESET);
            rtc_prescale_preset_r <= RTC_PRESCALE_W'(RTC_PRESCALE_RESET);
            gp_prescale_preset_r  <= GP_PRESCALE_W'(GP_PRESCALE_RESET);
        end else begin
            if (hit_wr(RTC_COUNT_ADDR)) begin
                rtc_count_preset_r <= COUNT_W'(lane_merge(32'(rtc_count_preset_r), wdata, sel_i));
            end
            if (hit_wr(GP_COUNT_ADDR)) begin
                gp_count_preset_r <= COUNT_W'(lane_merge(32'(gp_count_preset_r), wdata, sel_i));
            end
            if (hit_wr(RTC_PRESCALE_ADDR)) begin
                rtc_prescale_preset_r <= RTC_PRESCALE_W'(
                    lane_merge(32'(rtc_prescale_preset_r), wdata, sel_i));
            end
            if (hit_wr(GP_PRESCALE_ADDR)) begin
                gp_prescale_preset_r <= GP_PRESCALE_W'(
                    lane_merge(32'(gp_prescale_preset_r), wdata, sel_i));
            end
        end
    end

    // control register: mode bits stored, load bits act as one-cycle strobes
    // reserved control bits are dropped, so only the eight defined bits have any effect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_mode_r.reload_at_zero  <= GP_RELOAD_RESET;
            gp_mode_r.enable          <= 1'b0;
            rtc_mode_r.reload_at_zero <= RTC_RELOAD_RESET;
            rtc_mode_r.enable         <= 1'b0;
        end else if (hit_wr(TIMER_CTRL_ADDR)) begin
            // the register is write-only as a word; partial lanes still update their byte
            if (sel_i[0]) begin
                gp_mode_r.reload_at_zero <= wdata[GP_RELOAD_AT_ZERO_BIT];
                gp_mode_r.enable         <= wdata[GP_COUNT_ENABLE_BIT];
            end
            if (sel_i[1]) begin
                rtc_mode_r.reload_at_zero <= wdata[RTC_RELOAD_AT_ZERO_BIT];
                rtc_mode_r.enable         <= wdata[RTC_COUNT_ENABLE_BIT];
            end
        end
    end

    // load strobes: writing zero to a load bit does nothing
    // the strobes last only the ack cycle of the control write
    always_comb begin
        gp_load.count_load     = hit_wr(TIMER_CTRL_ADDR) && sel_i[0] && wdata[GP_COUNT_LOAD_BIT];
        gp_load.prescale_load  = hit_wr(TIMER_CTRL_ADDR) && sel_i[0] && wdata[GP_PRESCALE_LOAD_BIT];
        rtc_load.count_load    = hit_wr(TIMER_CTRL_ADDR) && sel_i[1] && wdata[RTC_COUNT_LOAD_BIT];
        rtc_load.prescale_load = hit_wr(TIMER_CTRL_ADDR) && sel_i[1] && wdata[RTC_PRESCALE_LOAD_BIT];
    end

    // prescaler underflow ticks the counter; a stopped counter at zero stays idle
    // a counter loaded with zero never ticks, so it can never expire
    assign rtc_tick   = rtc_mode_r.enable && (rtc_prescale_value_r == '0)
                        && (rtc_count_value_r != '0);
    assign gp_tick    = gp_mode_r.enable && (gp_prescale_value_r == '0)
                        && (gp_count_value_r != '0);
    assign rtc_expire = rtc_tick && (rtc_count_value_r == COUNT_W'(1));
    assign gp_expire  = gp_tick && (gp_count_value_r == COUNT_W'(1));

    // rtc prescaler next value: a load strobe wins, a disabled channel holds its value
    always_comb begin
        rtc_prescale_nxt = rtc_prescale_value_r;
        if (rtc_load.prescale_load) begin
            rtc_prescale_nxt = rtc_prescale_preset_r;
        end else if (rtc_mode_r.enable) begin
            rtc_prescale_nxt = RTC_PRESCALE_W'(prescale_step(32'(rtc_prescale_value_r),
                                                             32'(rtc_prescale_preset_r)));
        end
    end

    // rtc prescaler register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_prescale_value_r <= RTC_PRESCALE_W'(RTC_PRESCALE_RESET);
        end else begin
            rtc_prescale_value_r <= rtc_prescale_nxt;
        end
    end

    // rtc counter next value: the last step reloads the preset or lands on zero, per the reload mode bit
    // a load in the same cycle as an expiry wins, so software can restart a period at once
    always_comb begin
        if (rtc_load.count_load) begin
            rtc_count_nxt = rtc_count_preset_r;
        end else begin
            rtc_count_nxt = COUNT_W'(count_step(32'(rtc_count_value_r), 32'(rtc_count_preset_r),
                                                rtc_tick, rtc_mode_r.reload_at_zero));
        end
    end

    // rtc counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_count_value_r <= COUNT_W'(COUNT_RESET);
        end else begin
            rtc_count_value_r <= rtc_count_nxt;
        end
    end

    // gp prescaler next value: a load strobe wins, a disabled channel holds its value
    always_comb begin
        gp_prescale_nxt = gp_prescale_value_r;
        if (gp_load.prescale_load) begin
            gp_prescale_nxt = gp_prescale_preset_r;
        end else if (gp_mode_r.enable) begin
            gp_prescale_nxt = GP_PRESCALE_W'(prescale_step(32'(gp_prescale_value_r),
                                                           32'(gp_prescale_preset_r)));
        end
    end

    // gp prescaler register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_prescale_value_r <= GP_PRESCALE_W'(GP_PRESCALE_RESET);
        end else begin
            gp_prescale_value_r <= gp_prescale_nxt;
        end
    end

    // gp counter next value: the last step reloads the preset or lands on zero, per the reload mode bit
    // a load in the same cycle as an expiry wins, so software can restart a period at once
    always_comb begin
        if (gp_load.count_load) begin
            gp_count_nxt = gp_count_preset_r;
        end else begin
            gp_count_nxt = COUNT_W'(count_step(32'(gp_count_value_r), 32'(gp_count_preset_r),
                                               gp_tick, gp_mode_r.reload_at_zero));
        end
    end

    // gp counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_count_value_r <= COUNT_W'(COUNT_RESET);
        end else begin
            gp_count_value_r <= gp_count_nxt;
        end
    end

    // one-cycle request pulses toward the interrupt controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_irq_r <= 1'b0;
            gp_irq_r  <= 1'b0;
        end else begin
            rtc_irq_r <= rtc_expire;
            gp_irq_r  <= gp_expire;
        end
    end

    assign rtc_irq_o = rtc_irq_r;
    assign gp_irq_o  = gp_irq_r;

    // write-one-to-clear strobes for the sticky status
    // a process rather than an assign, so the bus signals read inside hit_wr wake it
    always_comb begin
        irq_clear = 2'b00;
        if (hit_wr(IRQ_CLEAR_ADDR) && sel_i[0]) begin
            irq_clear = wdata[1:0];
        end
    end

    // expiry events in status bit order
    always_comb begin
        irq_set              = 2'b00;
        irq_set[IRQ_RTC_BIT] = rtc_expire;
        irq_set[IRQ_GP_BIT]  = gp_expire;
    end

    // sticky status: a new expiry in the clear cycle wins over the clear
    // so clearing a bit whose event fires in that cycle loses no expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_r <= 2'b00;
        end else begin
            irq_status_r <= irq_set | (irq_status_r & ~irq_clear);
        end
    end

    // interrupt enable register
    // only the low byte lane holds enable bits; other lanes are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_r <= 2'b00;
        end else if (hit_wr(IRQ_ENABLE_ADDR) && sel_i[0]) begin
            irq_enable_r <= wdata[1:0];
        end
    end

    // level interrupt while any enabled status bit is set
    // the per-channel pulses stay unmasked for a controller that counts edges
    assign irq_o = |(irq_status_r & irq_enable_r);

endmodule

// [verif/dual_prescaled_down_timers_checker.sv]
// Purpose: port-level checks of bus handshake and interrupt outputs of the timer block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   live counts are not visible at the ports, so timing of expiry is left to the bench
`timescale 1ns/100ps
module dual_prescaled_down_timers_checker
    import timer_pkg::*;
#(
    parameter int COUNT_W        = 32,
    parameter int RTC_PRESCALE_W = 8,
    parameter int GP_PRESCALE_W  = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        rtc_irq_o,
    input wire logic        gp_irq_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request that the slave takes at this edge
    sequence req_taken;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence rd_of(logic [31:0] a);
        req_taken ##0 (!we_i && adr_i == a);
    endsequence
    // a write lands at the edge where the slave's ack is sampled
    sequence wr_of(logic [31:0] a);
        cyc_i && stb_i && ack_o && we_i && adr_i == a;
    endsequence

    ack_follows_a: assert property (req_taken |=> ack_o) else $error("request not answered");
    ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    // read data must stay quiet outside a read answer, so a stale value cannot be taken
    data_quiet_a: assert property ((!ack_o || $past(we_i)) |-> dat_o == 32'h00000000)
        else $error("read data not zero");
    rtc_upper_a: assert property (rd_of(RTC_PRESCALE_ADDR) |=> dat_o[31:8] == 24'h000000)
        else $error("rtc prescaler upper bits set");
    gp_upper_a: assert property (rd_of(GP_PRESCALE_ADDR) |=> dat_o[31:16] == 16'h0000)
        else $error("gp prescaler upper bits set");
    ctrl_reads_zero_a: assert property (rd_of(TIMER_CTRL_ADDR) |=> dat_o == 32'h00000000)
        else $error("control register not write only");
    mask_off_a: assert property ((wr_of(IRQ_ENABLE_ADDR) ##0 (sel_i[0] && dat_i[1:0] == 2'b00))
        |=> !irq_o) else $error("masked interrupt still raised");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !rtc_irq_o && !gp_irq_o)
        else $error("outputs active after reset");
endmodule

bind dual_prescaled_down_timers dual_prescaled_down_timers_checker #(
    .COUNT_W        (COUNT_W),
    .RTC_PRESCALE_W (RTC_PRESCALE_W),
    .GP_PRESCALE_W  (GP_PRESCALE_W)
) u_dual_prescaled_down_timers_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rtc_irq_o(rtc_irq_o),
    .gp_irq_o(gp_irq_o), .irq_o(irq_o)
);

// [verif/dual_prescaled_down_timers_tb_top.sv]
// Purpose: self-checking bench for the dual prescaled timer block
// Assumes: classic wishbone single cycles, 20 MHz clock
// Notes:   first expiry is checked in a small window, later periods exactly
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module dual_prescaled_down_timers_tb_top;
    import timer_pkg::*;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [31:0] adr  = 32'h00000000;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic        ack, rtc_irq, gp_irq, irq;
    logic [31:0] q, q2;
    int          n_fail = 0;
    int          comparisons = 0;
    int          n;

    always #25 clk = ~clk;

    dual_prescaled_down_timers u_dual_prescaled_down_timers (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .rtc_irq_o(rtc_irq), .gp_irq_o(gp_irq), .irq_o(irq)
    );

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        k = 0;
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
        if (k >= 50) `CHK(ack, 1'b1)
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h00000000, r);
    endtask
    // clocks until the chosen interrupt pulse is seen, bounded
    task automatic wait_irq(input bit gp, output int k);
        k = 0;
        do begin @(posedge clk); k++; end while ((gp ? gp_irq : rtc_irq) !== 1'b1 && k < 1000);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values
        rd(RTC_COUNT_ADDR, q);     `CHK(q, 32'hFFFFFFFF)
        rd(RTC_PRESCALE_ADDR, q);  `CHK(q, 32'h000000FF)
        rd(GP_COUNT_ADDR, q);      `CHK(q, 32'hFFFFFFFF)
        rd(GP_PRESCALE_ADDR, q);   `CHK(q, 32'h0000FFFF)
        rd(TIMER_CTRL_ADDR, q);    `CHK(q, 32'h00000000)
        rd(32'h01F800FC, q);       `CHK(q, 32'h00000000)
        // presets must not reach the live values
        wr(RTC_COUNT_ADDR, 32'h00000005);
        wr(RTC_PRESCALE_ADDR, 32'h00000003);
        wr(GP_COUNT_ADDR, 32'h00000003);
        wr(GP_PRESCALE_ADDR, 32'h00000001);
        rd(RTC_COUNT_ADDR, q);     `CHK(q, 32'hFFFFFFFF)
        rd(RTC_PRESCALE_ADDR, q);  `CHK(q, 32'h000000FF)
        rd(GP_PRESCALE_ADDR, q);   `CHK(q, 32'h0000FFFF)
        // loads while disabled: values arrive and then hold
        wr(TIMER_CTRL_ADDR, 32'h00000A0A);
        repeat (20) @(posedge clk);
        rd(RTC_COUNT_ADDR, q);     `CHK(q, 32'h00000005)
        rd(RTC_PRESCALE_ADDR, q);  `CHK(q, 32'h00000003)
        rd(GP_COUNT_ADDR, q);      `CHK(q, 32'h00000003)
        rd(GP_PRESCALE_ADDR, q);   `CHK(q, 32'h00000001)
        wr(IRQ_ENABLE_ADDR, 32'h00000003);
        // rtc with reload: period 5 * (3 + 1)
        wr(TIMER_CTRL_ADDR, 32'h00000F00);
        wait_irq(1'b0, n);         `CHK(n >= 18 && n <= 22, 1'b1)
        `CHK(irq, 1'b1)
        wait_irq(1'b0, n);         `CHK(n, 20)
        // disable: count holds, then clear the sticky bit
        wr(TIMER_CTRL_ADDR, 32'h00000100);
        rd(RTC_COUNT_ADDR, q);
        repeat (10) @(posedge clk);
        rd(RTC_COUNT_ADDR, q2);    `CHK(q2, q)
        rd(IRQ_STATUS_ADDR, q);    `CHK(q[0], 1'b1)
        wr(IRQ_CLEAR_ADDR, 32'h00000001);
        rd(IRQ_STATUS_ADDR, q);    `CHK(q[0], 1'b0)
        `CHK(irq, 1'b0)
        // gp single shot: period 3 * (1 + 1), then stops at zero
        wr(TIMER_CTRL_ADDR, 32'h0000000E);
        wait_irq(1'b1, n);         `CHK(n >= 4 && n <= 8, 1'b1)
        `CHK(irq, 1'b1)
        wr(IRQ_ENABLE_ADDR, 32'h00000000);
        @(posedge clk);
        `CHK(irq, 1'b0)
        n = 0;
        repeat (30) begin @(posedge clk); if (gp_irq === 1'b1) n++; end
        `CHK(n, 0)
        rd(GP_COUNT_ADDR, q);      `CHK(q, 32'h00000000)
        // gp with reload keeps expiring at the same period
        wr(IRQ_ENABLE_ADDR, 32'h00000003);
        wr(TIMER_CTRL_ADDR, 32'h0000000F);
        wait_irq(1'b1, n);
        wait_irq(1'b1, n);         `CHK(n, 6)
        stop_test();
    end
endmodule
